// ==== verilog/tpr_regs.sv ====
// Register bank for oscillator band and selection, synthesiser dividers,
// baseband amplifier gain and the two baseband filter bandwidth settings.
// Assumes an AXI4-Lite master on clock_in and a tuning engine that
// reports its choices on tune_in.
//
// What this block does
// RULE1 - Reading the band bit returns the band the auto-tuner chose.
// RULE2 - Writing the band bit makes the written value the active band.
// RULE3 - One band bit for all oscillators; 0 high band, 1 low band.
// RULE4 - First filter code 00,01,10,11 gives 100,65,40,35 MHz.
// RULE5 - Software should use code 01 for 30 to 45 Msps.
// RULE6 - Software should use code 10 for 20 to 30 Msps.
// RULE7 - Software should use code 11 for 1 to 20 Msps.
// RULE8 - Dividers assemble from byte registers, high bits at lower offsets.
`timescale 1ns/1ps
`include "tpr_cfg.svh"
module tpr_regs (
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic [7:0]        s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [7:0]        s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire tpr_pkg::tpr_tune_s tune_in,
  output tpr_pkg::tpr_ctrl_s     ctrl_out
);
  import tpr_pkg::*;

  localparam int NREG = 8;

  // Tuner report comes from a separate engine; two flops before use
  tpr_tune_s tune_meta_reg;
  tpr_tune_s tune_sync_reg;

  // Write path: address and data may arrive in either order
  logic       aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic       w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // A channel is taken only on an edge where its ready flop is high
  wire aw_take  = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take   = s_axi_wvalid_in && s_axi_wready_out;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  // Occupancy after this edge, so a ready flop never offers a slot
  // that the same edge has just filled
  wire aw_held_next = !do_write && (aw_take || aw_held_reg);
  wire w_held_next  = !do_write && (w_take || w_held_reg);
  wire bvalid_next  = do_write || (bvalid_reg && !s_axi_bready_in);
  wire [7:0] wr_off = aw_addr_reg >> 2;
  wire wr_hit = (wr_off >= `TPR_OFF_AUTOTUNE_CFG_D) &&
                (wr_off <= `TPR_OFF_BB_FILTER_BW) &&
                (aw_addr_reg[1:0] == 2'b00);
  wire wr_en_byte = do_write && wr_hit && w_strb_reg[0];
  wire [2:0] wr_idx = 3'(wr_off - `TPR_OFF_AUTOTUNE_CFG_D);
  wire [7:0] wr_byte = w_data_reg[7:0];

  logic [7:0] reg_q [NREG];
  localparam logic [7:0] RST_VAL [NREG] = '{
    `TPR_RST_ZERO, `TPR_RST_ZERO, `TPR_RST_ZERO, `TPR_RST_ZERO,
    `TPR_RST_ZERO, `TPR_RST_PLL_FRAC_LO, `TPR_RST_ZERO, `TPR_RST_ZERO};

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      tpr_byte_reg #(.RESET_VALUE(RST_VAL[gi])) u_reg (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .write_in (wr_en_byte && (wr_idx == 3'(gi))),
        .data_in  (wr_byte),
        .q_out    (reg_q[gi])
      );
    end
  endgenerate

  // Byte views, lower offset holds the more significant bits
  wire [7:0] r_cfg   = reg_q[0];
  wire [7:0] r_osc   = reg_q[1];
  wire [7:0] r_int   = reg_q[2];
  wire [7:0] r_intfr = reg_q[3];
  wire [7:0] r_frmid = reg_q[4];
  wire [7:0] r_frlo  = reg_q[5];
  wire [7:0] r_gain  = reg_q[6];
  wire [7:0] r_bw    = reg_q[7];

  // Oscillator selection read-back shows the tuner's choice, not the
  // last write; the written value drives the oscillator until the next write
  wire [7:0] osc_readback = {tune_sync_reg.choice[5],
                             tune_sync_reg.local_div,
                             tune_sync_reg.choice[4:0],
                             tune_sync_reg.band}; // RULE1

  wire [7:0] rd_off = s_axi_araddr_in >> 2;
  wire rd_hit = (rd_off >= `TPR_OFF_AUTOTUNE_CFG_D) &&
                (rd_off <= `TPR_OFF_BB_FILTER_BW) &&
                (s_axi_araddr_in[1:0] == 2'b00);
  wire [2:0] rd_idx = 3'(rd_off - `TPR_OFF_AUTOTUNE_CFG_D);
  wire [7:0] rd_byte =
    (rd_idx == 3'(`TPR_OFF_OSC_SELECT - `TPR_OFF_AUTOTUNE_CFG_D)) ?
      osc_readback :
    (rd_idx == 3'(`TPR_OFF_BB_AMP_GAIN - `TPR_OFF_AUTOTUNE_CFG_D)) ?
      (reg_q[rd_idx] & `TPR_GAIN_MASK) :
    (rd_idx == 3'(`TPR_OFF_PLL_FRAC_LO - `TPR_OFF_AUTOTUNE_CFG_D)) ?
      (reg_q[rd_idx] & `TPR_FRAC_LO_MASK) : reg_q[rd_idx];
  wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
  wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready_in);

  // Bandwidth in MHz for the first baseband filter
  wire [7:0] bw_mhz =
    (r_bw[7:6] == 2'b00) ? `TPR_BW_MHZ_CODE0 :
    (r_bw[7:6] == 2'b01) ? `TPR_BW_MHZ_CODE1 :
    (r_bw[7:6] == 2'b10) ? `TPR_BW_MHZ_CODE2 :
                           `TPR_BW_MHZ_CODE3; // RULE4

  tpr_ctrl_s ctrl_next;
  always_comb begin
    ctrl_next = '0;
    // One bit serves all oscillators: 0 high band, 1 low band
    ctrl_next.osc_band_select          = r_osc[`TPR_BAND_BIT]; // RULE2 RULE3
    ctrl_next.local_osc_divider_choice = r_osc[`TPR_DIV_BIT];
    ctrl_next.osc_choice = {r_osc[`TPR_CHOICE_HI_BIT], r_osc[5:1]};
    ctrl_next.synth_integer_divider  = {r_int, r_intfr[7]}; // RULE8
    ctrl_next.synth_fraction_divider =
      {r_intfr[6:0], r_frmid, r_frlo[7:5]}; // RULE8
    ctrl_next.autotune_restart       = r_frlo[`TPR_RESTART_BIT];
    ctrl_next.autotune_cfg_d         = r_cfg;
    ctrl_next.bb_amp_gain_code       = r_gain[3:0];
    // Filter code range is left to software per symbol rate
    ctrl_next.first_bb_filter_width  = r_bw[7:6]; // RULE5 RULE6 RULE7
    ctrl_next.second_bb_filter_width = r_bw[5:0];
    ctrl_next.first_bb_filter_mhz    = bw_mhz;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tune_meta_reg <= '0;
      tune_sync_reg <= '0;
      ctrl_out      <= '0;
    end else begin
      tune_meta_reg <= tune_in;
      tune_sync_reg <= tune_meta_reg;
      ctrl_out      <= ctrl_next;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TPR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `TPR_RESP_OKAY : `TPR_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `TPR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp_reg  <= rd_hit ? `TPR_RESP_OKAY : `TPR_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Ready flags are registered so every output leaves a flop
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_arready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held_next && !bvalid_next;
      s_axi_wready_out  <= !w_held_next && !bvalid_next;
      s_axi_arready_out <= !rvalid_next;
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out  = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out  = rdata_reg;
  assign s_axi_rresp_out  = rresp_reg;
endmodule

// ==== verilog/tpr_cfg.svh ====
// Constants for the tuner oscillator, synthesiser and filter register bank.
// Assumes inclusion by bare name from the package and design files.
`ifndef TPR_CFG_SVH
`define TPR_CFG_SVH
`define TPR_OFF_AUTOTUNE_CFG_D   8'h17
`define TPR_OFF_OSC_SELECT       8'h18
`define TPR_OFF_PLL_INT_DIV_HI   8'h19
`define TPR_OFF_PLL_INT_LO_FRAC  8'h1a
`define TPR_OFF_PLL_FRAC_MID     8'h1b
`define TPR_OFF_PLL_FRAC_LO      8'h1c
`define TPR_OFF_BB_AMP_GAIN      8'h1d
`define TPR_OFF_BB_FILTER_BW     8'h1e
`define TPR_RST_ZERO             8'h00
`define TPR_RST_PLL_FRAC_LO      8'h10
`define TPR_BAND_BIT             0
`define TPR_DIV_BIT              6
`define TPR_CHOICE_HI_BIT        7
`define TPR_RESTART_BIT          4
`define TPR_GAIN_MASK            8'h0f
`define TPR_FRAC_LO_MASK         8'hf0
`define TPR_BW_MHZ_CODE0         8'd100
`define TPR_BW_MHZ_CODE1         8'd65
`define TPR_BW_MHZ_CODE2         8'd40
`define TPR_BW_MHZ_CODE3         8'd35
`define TPR_RESP_OKAY            2'b00
`define TPR_RESP_SLVERR          2'b10
`endif

// ==== verilog/tpr_pkg.sv ====
// Types shared by the register bank and its byte register cell.
// Assumes tpr_cfg.svh is on the include path.
`include "tpr_cfg.svh"
package tpr_pkg;
  typedef logic [7:0] tpr_byte_t;
  // Values chosen by the auto-tuner, fed in from the tuning engine
  typedef struct packed {
    logic       band;
    logic       local_div;
    logic [5:0] choice;
  } tpr_tune_s;
  // Settings presented to the analog and tuning logic
  typedef struct packed {
    logic        osc_band_select;
    logic        local_osc_divider_choice;
    logic [5:0]  osc_choice;
    logic [8:0]  synth_integer_divider;
    logic [17:0] synth_fraction_divider;
    logic        autotune_restart;
    logic [7:0]  autotune_cfg_d;
    logic [3:0]  bb_amp_gain_code;
    logic [1:0]  first_bb_filter_width;
    logic [5:0]  second_bb_filter_width;
    logic [7:0]  first_bb_filter_mhz;
  } tpr_ctrl_s;
endpackage

// ==== verilog/tpr_byte_reg.sv ====
// One byte register with write strobe and a reset value.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module tpr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic          clock_in,
  input  wire logic          nrst_in,
  input  wire logic          write_in,
  input  wire tpr_pkg::tpr_byte_t data_in,
  output logic               [7:0] q_out
);
  import tpr_pkg::*;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_out <= RESET_VALUE;
    end else if (write_in) begin
      q_out <= data_in;
    end
  end
endmodule

// ==== tb/tpr_regs_props.sv ====
// Checker for the tuner register bank's bus answers and settings.
// Assumes it is bound onto tpr_regs and sees only that module's ports.
`timescale 1ns/1ps
module tpr_regs_props (
  input wire logic               clock_in,
  input wire logic               nrst_in,
  input wire logic               s_axi_awready_out,
  input wire logic               s_axi_wready_out,
  input wire logic               s_axi_arvalid_in,
  input wire logic               s_axi_arready_out,
  input wire logic               s_axi_bvalid_out,
  input wire logic               s_axi_bready_in,
  input wire logic [31:0]        s_axi_rdata_out,
  input wire logic [1:0]         s_axi_rresp_out,
  input wire logic               s_axi_rvalid_out,
  input wire logic               s_axi_rready_in,
  input wire tpr_pkg::tpr_ctrl_s ctrl_out
);
  import tpr_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  write_resp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out) else $error("write answer dropped early");
  read_resp_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped or changed");
  write_ready_busy_a: assert property (s_axi_bvalid_out
    |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  write_ready_back_a: assert property ($fell(s_axi_bvalid_out)
    |-> s_axi_awready_out && s_axi_wready_out)
    else $error("write channels not ready again");
  read_ready_busy_a: assert property (s_axi_rvalid_out
    |-> !s_axi_arready_out) else $error("read taken while answer pending");
  read_ready_back_a: assert property ($fell(s_axi_rvalid_out)
    |-> s_axi_arready_out) else $error("read channel not ready again");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read answer late");
  read_upper_a: assert property (s_axi_rvalid_out
    |-> s_axi_rdata_out[31:8] == 24'h0) else $error("upper read bits set");
  err_data_a: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2
    |-> s_axi_rdata_out == 32'h0) else $error("error read carries data");
  reset_idle_a: assert property ($rose(nrst_in)
    |-> !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("busy at reset");
  restart_reset_a: assert property ($rose(nrst_in)
    |=> ctrl_out.autotune_restart) else $error("restart bit not at reset");
  filter_mhz_a: assert property ($past(nrst_in, 2) |->
    ctrl_out.first_bb_filter_mhz == (ctrl_out.first_bb_filter_width == 2'h0
    ? 8'd100 : ctrl_out.first_bb_filter_width == 2'h1 ? 8'd65
    : ctrl_out.first_bb_filter_width == 2'h2 ? 8'd40 : 8'd35))
    else $error("filter bandwidth decode wrong");
endmodule
bind tpr_regs tpr_regs_props i_props (.*);

// ==== tb/tpr_tune_model.sv ====
// Tuning engine stand-in: presents the auto-tuner's choices.
// Assumes the bench sets the code; the bank synchronises it itself.
`timescale 1ns/1ps
module tpr_tune_model (
  input  wire logic          clock_in,
  input  wire logic [7:0]    code_in,
  output tpr_pkg::tpr_tune_s tune_out
);
  import tpr_pkg::*;
  // Steps only on the edge so the synchroniser never sees a glitch
  always_ff @(posedge clock_in) begin
    tune_out <= code_in;
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the tuner register bank over AXI4-Lite.
// Assumes tpr_cfg.svh on the include path and a 20 MHz clock.
`timescale 1ns/1ps
`include "tpr_cfg.svh"
module testbench;
  import tpr_pkg::*;
  logic        clock_in, nrst_in, awv, wv, brdy, arv, rrdy;
  logic        awrdy, wrdy, arrdy, bvalid, rvalid;
  logic [7:0]  awa, ara, code;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp;
  tpr_tune_s   tune;
  tpr_ctrl_s   ctrl;
  int          errors, n_compared, cycles;
  tpr_tune_model i_tune (.clock_in(clock_in), .code_in(code),
    .tune_out(tune));
  tpr_regs i_dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awrdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(brdy), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arrdy),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rrdy),
    .tune_in(tune), .ctrl_out(ctrl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, output logic [1:0] r);
    @(posedge clock_in);
    awa <= a;
    awv <= 1'b1;
    wd <= {24'h0, d};
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    brdy <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clock_in);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arrdy) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rd;
    r = rresp;
    rrdy <= 1'b0;
  endtask
  task automatic wok(input logic [7:0] off, d);
    logic [1:0] r;
    wr({off[5:0], 2'h0}, d, r);
    chk(r, `TPR_RESP_OKAY);
  endtask
  task automatic rok(input logic [7:0] off, e);
    logic [31:0] d;
    logic [1:0]  r;
    rdr({off[5:0], 2'h0}, d, r);
    chk(d, {24'h0, e});
    chk(r, `TPR_RESP_OKAY);
  endtask
  task automatic t_reset();
    for (logic [7:0] i = 8'h17; i <= 8'h1e; i++) begin
      rok(i, i == 8'h1c ? `TPR_RST_PLL_FRAC_LO : `TPR_RST_ZERO);
    end
    chk(ctrl.autotune_restart, 32'h1);
  endtask
  task automatic t_band();
    wok(8'h18, 8'hc3);
    @(posedge clock_in);
    chk(ctrl.osc_band_select, 32'h1);
    chk(ctrl.local_osc_divider_choice, 32'h1);
    chk(ctrl.osc_choice, 32'h21);
    rok(8'h18, 8'h00);
    code <= 8'ha5;
    repeat (4) @(posedge clock_in);
    rok(8'h18, {code[5], code[6], code[4:0], code[7]});
    wok(8'h18, 8'h00);
    @(posedge clock_in);
    chk(ctrl.osc_band_select, 32'h0);
  endtask
  task automatic t_div();
    wok(8'h19, 8'hab);
    wok(8'h1a, 8'hcd);
    wok(8'h1b, 8'h12);
    wok(8'h1c, 8'hef);
    @(posedge clock_in);
    chk(ctrl.synth_integer_divider, {8'hab, 1'h1});
    chk(ctrl.synth_fraction_divider, {7'h4d, 8'h12, 3'h7});
    chk(ctrl.autotune_restart, 32'h0);
    rok(8'h1c, 8'he0);
    wok(8'h1d, 8'hff);
    rok(8'h1d, 8'h0f);
    chk(ctrl.bb_amp_gain_code, 32'hf);
    wok(8'h17, 8'hf0);
    rok(8'h17, 8'hf0);
    chk(ctrl.autotune_cfg_d, 32'hf0);
  endtask
  task automatic t_filter();
    logic [7:0] mhz [4] = '{`TPR_BW_MHZ_CODE0, `TPR_BW_MHZ_CODE1,
                           `TPR_BW_MHZ_CODE2, `TPR_BW_MHZ_CODE3};
    for (logic [2:0] c = 3'h0; c < 3'h4; c++) begin
      wok(8'h1e, {c[1:0], 6'h2a});
      @(posedge clock_in);
      chk(ctrl.first_bb_filter_width, c[1:0]);
      chk(ctrl.first_bb_filter_mhz, mhz[c[1:0]]);
      chk(ctrl.second_bb_filter_width, 6'h2a);
      rok(8'h1e, {c[1:0], 6'h2a});
    end
  endtask
  task automatic t_err();
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h7c, 8'h55, r);
    chk(r, `TPR_RESP_SLVERR);
    wr(8'h5d, 8'h55, r);
    chk(r, `TPR_RESP_SLVERR);
    rdr(8'h00, d, r);
    chk(r, `TPR_RESP_SLVERR);
    chk(d, 32'h0);
    rok(8'h17, 8'hf0);
  endtask
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    {nrst_in, awv, wv, brdy, arv, rrdy, awa, ara, wd, code} = '0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_reset();
    t_band();
    t_div();
    t_filter();
    t_err();
    end_sim();
  end
endmodule
